// [cmp_pwm_params.svh]
// Register offsets, field positions, reset values and timing constants
`ifndef CMP_PWM_PARAMS_SVH
`define CMP_PWM_PARAMS_SVH
// Register indices as printed; byte address is four times the index
`define IDX_FLAGS_ONE      8'h0c
`define IDX_T1_LOW         8'h0e
`define IDX_T1_HIGH        8'h0f
`define IDX_T1_CONTROL     8'h10
`define IDX_T2_COUNT       8'h11
`define IDX_T2_CONTROL     8'h12
`define IDX_CMP_LOW        8'h15
`define IDX_CMP_HIGH       8'h16
`define IDX_MATCH_CONTROL  8'h17
`define IDX_ENABLES_ONE    8'h8c
`define IDX_T2_PERIOD      8'h92
`define IDX_PIN_STATUS     8'h93
`define ADDR_BITS          10
// Flag bit positions
`define FLAG_T1_OVF        0
`define FLAG_T2_MATCH      1
`define FLAG_MATCH_EVENT   2
`define FLAGS_USED_MASK    8'h07
// Control fields
`define T1_ON_BIT          0
`define T2_ON_BIT          2
`define MODE_LSB           0
`define DUTY_LOW_LSB       4
// Reset values
`define RST_T2_PERIOD      8'hff
`define RST_ZERO           8'h00
// Prescale divisors minus one
`define PRE_DIV1           4'h0
`define PRE_DIV4           4'h3
`define PRE_DIV16          4'hf
`endif

// [cmp_pwm_pkg.sv]
// Types for the compare and pulse unit
package cmp_pwm_pkg;
   typedef enum logic [3:0]
   {
      MODE_OFF     = 4'b0000,
      MODE_CMP_SET = 4'b1000,
      MODE_CMP_CLR = 4'b1001,
      MODE_CMP_SW  = 4'b1010,
      MODE_CMP_SPC = 4'b1011,
      MODE_PWM     = 4'b1100
   } match_mode_t;
   typedef logic [7:0]  byte_t;
   typedef logic [15:0] word16_t;
endpackage

// [prescale_tick.sv]
// Programmable prescaler giving a one-cycle tick
`include "cmp_pwm_params.svh"
module prescale_tick
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        run,
   input  wire logic [1:0]  sel,
   output logic             tick
);
   logic [3:0] cnt_reg;
   logic [3:0] lim;
   always_comb
   begin
      case (sel)
         2'b00:   lim = `PRE_DIV1;
         2'b01:   lim = `PRE_DIV4;
         default: lim = `PRE_DIV16;
      endcase
   end
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_reg <= 4'h0;
      else if (!run || cnt_reg >= lim)
         cnt_reg <= 4'h0;
      else
         cnt_reg <= cnt_reg + 4'h1;
   end
   assign tick = run && (cnt_reg >= lim);
endmodule

// [duty_compare.sv]
// Ten-bit duty comparator against the extended time base
module duty_compare
(
   input  wire logic [9:0] duty,
   input  wire logic [9:0] base,
   output logic            hit
);
   // Duty above the period never equals a reachable base, so no clear
   assign hit = (duty == base);
endmodule

// [compare_and_pwm_unit.sv]
// Compare and pulse-width unit with AXI4-Lite register access
`include "cmp_pwm_params.svh"
module compare_and_pwm_unit
(
   input  wire logic                  MCLK,
   input  wire logic                  RST,
   input  wire logic [`ADDR_BITS-1:0] AWADDR,
   input  wire logic                  AWVALID,
   output logic                       AWREADY,
   input  wire logic [31:0]           WDATA,
   input  wire logic [3:0]            WSTRB,
   input  wire logic                  WVALID,
   output logic                       WREADY,
   output logic [1:0]                 BRESP,
   output logic                       BVALID,
   input  wire logic                  BREADY,
   input  wire logic [`ADDR_BITS-1:0] ARADDR,
   input  wire logic                  ARVALID,
   output logic                       ARREADY,
   output logic [31:0]                RDATA,
   output logic [1:0]                 RRESP,
   output logic                       RVALID,
   input  wire logic                  RREADY,
   input  wire logic                  CONV_ENABLED,
   output logic                       CONV_START,
   output logic                       MATCH_OUTPUT_PIN,
   output logic                       IRQ
);
   import cmp_pwm_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   logic                  aw_hold_reg;
   logic                  w_hold_reg;
   logic [`ADDR_BITS-1:0] awaddr_reg;
   logic [31:0]           wdata_reg;
   logic [3:0]            wstrb_reg;
   logic                  wr_go;
   logic [7:0]            wr_idx;
   logic [7:0]            wbyte;
   logic                  wr_hit;
   logic                  rd_hit;
   logic [7:0]            rd_idx;
   byte_t                 rd_val;
   byte_t                 flags_reg;
   byte_t                 enables_reg;
   word16_t               t1_reg;
   byte_t                 t1_ctrl_reg;
   byte_t                 t2_reg;
   byte_t                 t2_ctrl_reg;
   byte_t                 period_reg;
   word16_t               cmp_reg;
   byte_t                 ctrl_reg;
   logic [1:0]            t2_sub_reg;
   logic [7:0]            duty_hi_reg;
   logic [1:0]            duty_lo_reg;
   logic                  pin_reg;
   logic                  match;
   logic                  t2_tick;
   logic                  t2_period_hit;
   logic                  duty_hit;
   logic                  spc_clear;
   logic                  t1_ovf;
   match_mode_t           mode;
   logic                  cmp_mode;

   assign mode     = match_mode_t'(ctrl_reg[`MODE_LSB+3:`MODE_LSB]);
   assign cmp_mode = (ctrl_reg[3:2] == 2'b10);

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data accepted in either order
   assign wr_go  = aw_hold_reg && w_hold_reg && !BVALID;
   assign wr_idx = awaddr_reg[9:2];
   assign wbyte  = wdata_reg[7:0];
   assign wr_hit = wr_go && wstrb_reg[0];

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= 32'h0;
         wstrb_reg   <= 4'h0;
         AWREADY     <= 1'b0;
         WREADY      <= 1'b0;
         BVALID      <= 1'b0;
         BRESP       <= 2'b00;
      end
      else
      begin
         AWREADY <= !aw_hold_reg && !AWREADY && !BVALID;
         WREADY  <= !w_hold_reg && !WREADY && !BVALID;
         if (AWVALID && AWREADY)
         begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= AWADDR;
         end
         if (WVALID && WREADY)
         begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= WDATA;
            wstrb_reg  <= WSTRB;
         end
         if (wr_go)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            AWREADY     <= 1'b0;
            WREADY      <= 1'b0;
            BVALID      <= 1'b1;
            BRESP       <= (awaddr_reg[1:0] == 2'b00 && is_mapped(wr_idx)) ? 2'b00 : 2'b10;
         end
         else if (BVALID && BREADY)
            BVALID <= 1'b0;
      end
   end

   function automatic logic is_mapped(input logic [7:0] idx);
      case (idx)
         `IDX_FLAGS_ONE, `IDX_T1_LOW, `IDX_T1_HIGH, `IDX_T1_CONTROL, `IDX_T2_COUNT,
         `IDX_T2_CONTROL, `IDX_CMP_LOW, `IDX_CMP_HIGH, `IDX_MATCH_CONTROL,
         `IDX_ENABLES_ONE, `IDX_T2_PERIOD, `IDX_PIN_STATUS: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Read channel: answer on the same edge that takes the address
   assign rd_idx = ARADDR[9:2];
   assign rd_hit = ARVALID && ARREADY;

   always_comb
   begin
      case (rd_idx)
         `IDX_FLAGS_ONE:     rd_val = flags_reg;
         `IDX_T1_LOW:        rd_val = t1_reg[7:0];
         `IDX_T1_HIGH:       rd_val = t1_reg[15:8];
         `IDX_T1_CONTROL:    rd_val = t1_ctrl_reg;
         `IDX_T2_COUNT:      rd_val = t2_reg;
         `IDX_T2_CONTROL:    rd_val = t2_ctrl_reg;
         `IDX_CMP_LOW:       rd_val = cmp_reg[7:0];
         `IDX_CMP_HIGH:      rd_val = cmp_reg[15:8];
         `IDX_MATCH_CONTROL: rd_val = ctrl_reg;
         `IDX_ENABLES_ONE:   rd_val = enables_reg;
         `IDX_T2_PERIOD:     rd_val = period_reg;
         `IDX_PIN_STATUS:    rd_val = {7'h00, pin_reg};
         default:            rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= 32'h0;
         RRESP   <= 2'b00;
      end
      else
      begin
         ARREADY <= !ARREADY && !RVALID && ARVALID;
         if (rd_hit)
         begin
            RVALID <= 1'b1;
            RDATA  <= {24'h0, rd_val};
            RRESP  <= (ARADDR[1:0] == 2'b00 && is_mapped(rd_idx)) ? 2'b00 : 2'b10;
         end
         else if (RVALID && RREADY)
            RVALID <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         t1_ctrl_reg <= `RST_ZERO;
         t2_ctrl_reg <= `RST_ZERO;
         period_reg  <= `RST_T2_PERIOD;
         cmp_reg     <= 16'h0000;
         ctrl_reg    <= `RST_ZERO;
         enables_reg <= `RST_ZERO;
      end
      else if (wr_hit)
      begin
         case (wr_idx)
            `IDX_T1_CONTROL:    t1_ctrl_reg <= {1'b0, wbyte[6:0]};
            `IDX_T2_CONTROL:    t2_ctrl_reg <= {1'b0, wbyte[6:0]};
            `IDX_T2_PERIOD:     period_reg  <= wbyte;
            `IDX_CMP_LOW:       cmp_reg[7:0]  <= wbyte;
            `IDX_CMP_HIGH:      cmp_reg[15:8] <= wbyte;
            `IDX_MATCH_CONTROL: ctrl_reg    <= {2'b00, wbyte[5:0]};
            `IDX_ENABLES_ONE:   enables_reg <= wbyte & `FLAGS_USED_MASK;
            default:            ctrl_reg    <= ctrl_reg;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer one, cleared by the special event
   assign match     = cmp_mode && (t1_reg == cmp_reg);
   assign spc_clear = match && (mode == MODE_CMP_SPC);
   assign t1_ovf    = t1_ctrl_reg[`T1_ON_BIT] && (t1_reg == 16'hffff) && !spc_clear;

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         t1_reg <= 16'h0000;
      else if (wr_hit && wr_idx == `IDX_T1_LOW)
         t1_reg[7:0] <= wbyte;
      else if (wr_hit && wr_idx == `IDX_T1_HIGH)
         t1_reg[15:8] <= wbyte;
      else if (spc_clear)
         t1_reg <= 16'h0000;
      else if (t1_ctrl_reg[`T1_ON_BIT])
         t1_reg <= t1_reg + 16'h0001;
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         CONV_START <= 1'b0;
      else
         CONV_START <= spc_clear && CONV_ENABLED;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Timer two time base with two extra fraction bits
   prescale_tick u_pre
   (
      .clk  (MCLK),
      .rst  (RST),
      .run  (t2_ctrl_reg[`T2_ON_BIT]),
      .sel  (t2_ctrl_reg[1:0]),
      .tick (t2_tick)
   );

   assign t2_period_hit = t2_tick && (t2_reg == period_reg) && (t2_sub_reg == 2'b11);

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         t2_reg     <= `RST_ZERO;
         t2_sub_reg <= 2'b00;
      end
      else if (wr_hit && wr_idx == `IDX_T2_COUNT)
      begin
         t2_reg     <= wbyte;
         t2_sub_reg <= 2'b00;
      end
      else if (t2_period_hit)
      begin
         t2_reg     <= 8'h00;
         t2_sub_reg <= 2'b00;
      end
      else if (t2_tick)
         {t2_reg, t2_sub_reg} <= {t2_reg, t2_sub_reg} + 10'h001;
   end

   // Duty is latched at each period boundary so a cycle is never torn
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
      begin
         duty_hi_reg <= 8'h00;
         duty_lo_reg <= 2'b00;
      end
      else if (t2_period_hit || mode != MODE_PWM)
      begin
         duty_hi_reg <= cmp_reg[7:0];
         duty_lo_reg <= ctrl_reg[`DUTY_LOW_LSB+1:`DUTY_LOW_LSB];
      end
   end

   // Next base value, so the pin drops on the edge the match begins, not one step late
   duty_compare u_duty
   (
      .duty (({duty_hi_reg, duty_lo_reg})),
      .base ({t2_reg, t2_sub_reg} + 10'h001),
      .hit  (duty_hit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Output latch
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         pin_reg <= 1'b0;
      else if (wr_hit && wr_idx == `IDX_MATCH_CONTROL && wbyte == 8'h00)
         pin_reg <= 1'b0;
      else if (mode == MODE_PWM)
      begin
         if (t2_period_hit)
            pin_reg <= (({duty_hi_reg, duty_lo_reg}) != 10'h000);
         else if (duty_hit && t2_tick)
            pin_reg <= 1'b0;
      end
      else if (match && mode == MODE_CMP_SET)
         pin_reg <= 1'b1;
      else if (match && mode == MODE_CMP_CLR)
         pin_reg <= 1'b0;
   end
   assign MATCH_OUTPUT_PIN = pin_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags: hardware set wins over write-one clear
   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         flags_reg <= `RST_ZERO;
      else
      begin
         if (wr_hit && wr_idx == `IDX_FLAGS_ONE)
            flags_reg <= flags_reg & ~wbyte;
         if (match)
            flags_reg[`FLAG_MATCH_EVENT] <= 1'b1;
         if (t1_ovf)
            flags_reg[`FLAG_T1_OVF] <= 1'b1;
         if (t2_period_hit)
            flags_reg[`FLAG_T2_MATCH] <= 1'b1;
      end
   end

   always_ff @(posedge MCLK or posedge RST)
   begin
      if (RST)
         IRQ <= 1'b0;
      else
         IRQ <= |(flags_reg & enables_reg);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_match_flag: assert property (@(posedge MCLK) disable iff (RST)
      match |=> flags_reg[`FLAG_MATCH_EVENT])
      else $error("match flag not set");
   a_pin_high: assert property (@(posedge MCLK) disable iff (RST)
      (match && mode == MODE_CMP_SET && !wr_hit) |=> pin_reg)
      else $error("pin not driven high");
   a_pin_low: assert property (@(posedge MCLK) disable iff (RST)
      (match && mode == MODE_CMP_CLR) |=> !pin_reg)
      else $error("pin not driven low");
   a_sw_keep: assert property (@(posedge MCLK) disable iff (RST)
      (mode == MODE_CMP_SW && !wr_hit) |=> $stable(pin_reg))
      else $error("software mode moved pin");
   a_spc_clear: assert property (@(posedge MCLK) disable iff (RST)
      (spc_clear && !wr_hit) |=> (t1_reg == 16'h0000))
      else $error("timer one not cleared");
   a_spc_noovf: assert property (@(posedge MCLK) disable iff (RST)
      (spc_clear && !flags_reg[`FLAG_T1_OVF]) |=> !flags_reg[`FLAG_T1_OVF])
      else $error("special event set overflow");
   a_zero_ctrl: assert property (@(posedge MCLK) disable iff (RST)
      (wr_hit && wr_idx == `IDX_MATCH_CONTROL && wbyte == 8'h00) |=> !pin_reg)
      else $error("latch not cleared");
   a_conv_start: assert property (@(posedge MCLK) disable iff (RST)
      (spc_clear && CONV_ENABLED) |=> CONV_START)
      else $error("conversion not started");
   a_long_duty: assert property (@(posedge MCLK) disable iff (RST)
      (mode == MODE_PWM && pin_reg && {duty_hi_reg, duty_lo_reg} > {period_reg, 2'b11}
       && !t2_period_hit && !wr_hit) |=> pin_reg)
      else $error("pin cleared with long duty");
   a_period_rst: assert property (@(posedge MCLK) disable iff (RST)
      (t2_period_hit && !wr_hit) |=> (t2_reg == 8'h00))
      else $error("timer two not restarted");
   c_match: cover property (@(posedge MCLK) disable iff (RST) match);
   c_spc: cover property (@(posedge MCLK) disable iff (RST) spc_clear);
   c_pwm_cycle: cover property (@(posedge MCLK) disable iff (RST) t2_period_hit && mode == MODE_PWM);
endmodule

// [tb_top.sv]
// Self-checking bench for the compare and pulse unit
`include "cmp_pwm_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import cmp_pwm_pkg::*;

   logic                  MCLK;
   logic                  RST;
   logic [`ADDR_BITS-1:0] AWADDR;
   logic [`ADDR_BITS-1:0] ARADDR;
   logic                  AWVALID, WVALID, BREADY, ARVALID, RREADY, CONV_ENABLED;
   logic                  AWREADY, WREADY, BVALID, ARREADY, RVALID;
   logic                  CONV_START, MATCH_OUTPUT_PIN, IRQ;
   logic [31:0]           WDATA;
   logic [31:0]           RDATA;
   logic [3:0]            WSTRB;
   logic [1:0]            BRESP;
   logic [1:0]            RRESP;
   int                    err_count;
   int                    cmp_count;
   int                    cycles;

   compare_and_pwm_unit dut
   (
      .MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
      .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .CONV_ENABLED(CONV_ENABLED), .CONV_START(CONV_START),
      .MATCH_OUTPUT_PIN(MATCH_OUTPUT_PIN), .IRQ(IRQ)
   );

   initial MCLK = 1'b0;
   always #2 MCLK = ~MCLK;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      if (err_count == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Hang guard, well above the longest expected run
   always @(posedge MCLK)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         err_count++;
         give_verdict();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic [1:0] resp_of(input logic [7:0] idx);
      case (idx)
         8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12, 8'h15, 8'h16, 8'h17, 8'h8c, 8'h92, 8'h93:
            return 2'h0;
         default:
            return 2'h2;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Leading edge keeps a back-to-back call from driving a valid twice in one step
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bit aw;
      bit w;
      @(posedge MCLK);
      AWADDR  <= {idx, 2'h0};
      WDATA   <= {24'h0, d};
      WSTRB   <= 4'hf;
      AWVALID <= 1'b1;
      WVALID  <= 1'b1;
      BREADY  <= 1'b1;
      aw = 0;
      w = 0;
      while (!(aw && w))
      begin
         @(posedge MCLK);
         if (!aw && AWREADY === 1'b1)
         begin
            aw = 1;
            AWVALID <= 1'b0;
         end
         if (!w && WREADY === 1'b1)
         begin
            w = 1;
            WVALID <= 1'b0;
         end
      end
      do @(posedge MCLK); while (BVALID !== 1'b1);
      chk("bresp", 32'(resp_of(idx)), 32'(BRESP));
      BREADY <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] d);
      @(posedge MCLK);
      ARADDR  <= {idx, 2'h0};
      ARVALID <= 1'b1;
      RREADY  <= 1'b1;
      do @(posedge MCLK); while (ARREADY !== 1'b1);
      ARVALID <= 1'b0;
      while (RVALID !== 1'b1) @(posedge MCLK);
      d = RDATA;
      chk("rresp", 32'(resp_of(idx)), 32'(RRESP));
      RREADY <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp_case(input match_mode_t m, input logic pin_exp);
      logic [15:0] cv;
      logic [15:0] start;
      logic [31:0] d;
      logic        pin0;
      logic        conv_seen;
      int          pin_at;
      int          irq_at;
      cv = 16'(($urandom % 32'hfe00) + 32'h0100);
      start = cv - 16'h0028;
      wr(`IDX_T1_CONTROL, 8'h00);
      wr(`IDX_CMP_LOW, cv[7:0]);
      wr(`IDX_CMP_HIGH, cv[15:8]);
      wr(`IDX_T1_LOW, start[7:0]);
      wr(`IDX_T1_HIGH, start[15:8]);
      wr(`IDX_MATCH_CONTROL, {4'h0, m});
      wr(`IDX_FLAGS_ONE, 8'h07);
      pin0 = MATCH_OUTPUT_PIN;
      pin_at = -1;
      irq_at = -1;
      conv_seen = 0;
      wr(`IDX_T1_CONTROL, 8'h01);
      for (int i = 0; i < 200 && irq_at < 0; i++)
      begin
         @(posedge MCLK);
         if (pin_at < 0 && MATCH_OUTPUT_PIN !== pin0)
            pin_at = i;
         if (IRQ === 1'b1)
            irq_at = i;
         if (CONV_START === 1'b1)
            conv_seen = 1;
      end
      // Start pulse rises on the same edge as the flag, a cycle before IRQ
      repeat (3)
      begin
         @(posedge MCLK);
         if (CONV_START === 1'b1)
            conv_seen = 1;
      end
      chk("irq_on_match", 32'h1, 32'(irq_at >= 0));
      chk("match_pin", 32'(pin_exp), 32'(MATCH_OUTPUT_PIN));
      if (pin_exp !== pin0)
         chk("flag_with_pin", 32'(pin_at + 1), 32'(irq_at));
      chk("conv_start", 32'(m == MODE_CMP_SPC && CONV_ENABLED), 32'(conv_seen));
      rd(`IDX_FLAGS_ONE, d);
      chk("flags", 32'h4, d & 32'h5);
      rd(`IDX_T1_HIGH, d);
      chk("t1_restart", 32'(m == MODE_CMP_SPC), 32'(d[7:0] < cv[15:8]));
      wr(`IDX_T1_CONTROL, 8'h00);
   endtask

   task automatic pwm_case(input logic [1:0] pre, input logic [9:0] duty);
      int div;
      int hi;
      int ex;
      div = (pre == 2'h0) ? 1 : (pre == 2'h1) ? 4 : 16;
      ex = ((duty > 10'd32) ? 32 : int'(duty)) * div;
      wr(`IDX_T2_CONTROL, 8'h00);
      wr(`IDX_MATCH_CONTROL, 8'h00);
      wr(`IDX_T2_COUNT, 8'h00);
      wr(`IDX_T2_PERIOD, 8'h07);
      wr(`IDX_CMP_LOW, duty[9:2]);
      wr(`IDX_T2_CONTROL, {5'h0, 1'b1, pre});
      wr(`IDX_MATCH_CONTROL, {2'h0, duty[1:0], MODE_PWM});
      repeat (64 * div) @(posedge MCLK);
      hi = 0;
      // Window of exactly one period, so phase does not matter
      repeat (32 * div)
      begin
         @(posedge MCLK);
         hi += int'(MATCH_OUTPUT_PIN === 1'b1);
      end
      chk("pwm_high", 32'(ex), 32'(hi));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [31:0] d;
      logic [7:0]  ri[8] = '{8'h0c, 8'h10, 8'h11, 8'h12, 8'h17, 8'h8c, 8'h92, 8'h93};
      logic [7:0]  rv[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
      err_count = 0;
      cmp_count = 0;
      cycles = 0;
      RST = 1'b1;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY, CONV_ENABLED} = 6'h0;
      AWADDR = '0;
      ARADDR = '0;
      WDATA = 32'h0;
      WSTRB = 4'h0;
      void'($urandom(17931));
      repeat (2) @(posedge MCLK);
      RST <= 1'b0;
      foreach (ri[i])
      begin
         rd(ri[i], d);
         chk("reset_value", 32'(rv[i]), d);
      end
      // Unmapped place: dropped write, zero read
      wr(8'h20, 8'h5a);
      rd(8'h20, d);
      chk("unmapped_read", 32'h0, d);
      wr(`IDX_ENABLES_ONE, 8'h04);
      cmp_case(MODE_CMP_SET, 1'b1);
      wr(`IDX_ENABLES_ONE, 8'h00);
      repeat (2) @(posedge MCLK);
      chk("irq_masked", 32'h0, 32'(IRQ));
      wr(`IDX_ENABLES_ONE, 8'h04);
      repeat (2) @(posedge MCLK);
      chk("irq_unmasked", 32'h1, 32'(IRQ));
      wr(`IDX_FLAGS_ONE, 8'h04);
      repeat (2) @(posedge MCLK);
      chk("irq_cleared", 32'h0, 32'(IRQ));
      cmp_case(MODE_CMP_SW, 1'b1);
      cmp_case(MODE_CMP_CLR, 1'b0);
      cmp_case(MODE_CMP_SET, 1'b1);
      wr(`IDX_MATCH_CONTROL, 8'h00);
      rd(`IDX_PIN_STATUS, d);
      chk("latch_cleared", 32'h0, d);
      chk("pin_cleared", 32'h0, 32'(MATCH_OUTPUT_PIN));
      CONV_ENABLED <= 1'b0;
      cmp_case(MODE_CMP_SPC, 1'b0);
      CONV_ENABLED <= 1'b1;
      cmp_case(MODE_CMP_SPC, 1'b0);
      for (int p = 0; p < 3; p++)
         pwm_case(2'(p), 10'(1 + $urandom % 31));
      pwm_case(2'h0, 10'd32);
      pwm_case(2'h0, 10'd40);
      give_verdict();
   end
endmodule
